// ### core/sbst_pkg.sv
package sbst_pkg;

	//------------------------------------------------------------
	// register lengths
	//------------------------------------------------------------
	localparam int IR_LEN        = 3;
	localparam int ID_LEN        = 32;
	localparam int BSR_LEN       = 108;  // one cell per package bump
	localparam int BSR_FLOAT_BIT = 47;   // output-bus float control cell

	//------------------------------------------------------------
	// instruction codes and capture patterns
	//------------------------------------------------------------
	localparam logic [IR_LEN-1:0] INS_EXTEST  = 3'h0;
	localparam logic [IR_LEN-1:0] INS_IDCODE  = 3'h1;
	localparam logic [IR_LEN-1:0] INS_SAMPLEZ = 3'h2;
	localparam logic [IR_LEN-1:0] INS_SAMPLE  = 3'h4;
	localparam logic [IR_LEN-1:0] INS_BYPASS  = 3'h7;
	localparam logic [IR_LEN-1:0] IR_CAPTURE  = 3'h1;  // low two bits read 01
	localparam logic              BYP_CAPTURE = 1'h0;
	localparam logic              FLOAT_RESET = 1'h0;

	//------------------------------------------------------------
	// controller states, one-hot
	//------------------------------------------------------------
	typedef enum logic [15:0] {
		ST_TLR   = 16'h0001,
		ST_RTI   = 16'h0002,
		ST_SELDR = 16'h0004,
		ST_CAPDR = 16'h0008,
		ST_SHDR  = 16'h0010,
		ST_EX1DR = 16'h0020,
		ST_PAUDR = 16'h0040,
		ST_EX2DR = 16'h0080,
		ST_UPDR  = 16'h0100,
		ST_SELIR = 16'h0200,
		ST_CAPIR = 16'h0400,
		ST_SHIR  = 16'h0800,
		ST_EX1IR = 16'h1000,
		ST_PAUIR = 16'h2000,
		ST_EX2IR = 16'h4000,
		ST_UPIR  = 16'h8000
	} sbst_state_e;

endpackage

// ### core/sbst_tap.sv
`timescale 1ns/100ps
// Contract
// - power-up reset never disturbs memory operation
// - sample on rising, drive on falling edge
// - mode select sampled rising, pulled high
// - instruction selects exactly one serial path
// - shift in at msb, out at lsb
// - serial out driven only while shifting
// - five high mode-select edges reach reset
// - test reset leaves memory accesses alone
// - power-up reset floats serial output
// - instruction register is three bits, serial
// - reset state loads identification instruction
// - instruction capture loads 01 low bits
// - one-bit bypass, cleared when bypass applied
// - data capture loads pin ring, then shifts
// - ring capture under extest, sample, samplez
// - one scan cell per package bump
// - identification code captured and shifted out
// - samplez floats output bus until replaced
module sbst_tap
	import sbst_pkg::*;
#(
	parameter logic [ID_LEN-1:0] ID_CODE = 32'h0abc_d001  // arbitrary value
) (
	input  wire logic               clock,     // memory core clock
	input  wire logic               rst,       // power-up reset
	input  wire logic               tck,       // test clock
	input  wire logic               tms,       // mode select, pad pull-up
	input  wire logic               tdi,       // serial data in
	output logic                    tdoOut,    // serial data out level
	output logic                    tdoOe,     // serial data out enable
	input  wire logic [BSR_LEN-1:0] pinRing,   // live pin ring values
	output logic      [BSR_LEN-1:0] bsrDrive,  // latched preload pattern
	output logic                    extestOn,  // extest is current
	output logic                    qBusFloat  // memory output bus float
);

	//------------------------------------------------------------
	// declarations
	//------------------------------------------------------------
	sbst_state_e              state_reg;
	sbst_state_e              state_next;
	logic [IR_LEN-1:0]        irShift_reg;
	logic [IR_LEN-1:0]        irReg_reg;
	logic                     bypReg_reg;
	logic [ID_LEN-1:0]        idShift_reg;
	logic [BSR_LEN-1:0]       bsrShift_reg;
	logic [BSR_LEN-1:0]       bsrUpdate_reg;
	logic [BSR_LEN-1:0]       ringMeta_reg;
	logic [BSR_LEN-1:0]       ringSync_reg;
	logic                     tdoOut_reg;
	logic                     tdoOe_reg;
	logic                     extestOn_reg;
	logic                     floatReq_reg;
	logic                     floatMeta_reg;
	logic                     qBusFloat_reg;

	//------------------------------------------------------------
	// instruction decode
	//------------------------------------------------------------
	function automatic logic isRingIns(input logic [IR_LEN-1:0] ins);
		isRingIns = (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_SAMPLEZ);
	endfunction

	function automatic logic isBypassIns(input logic [IR_LEN-1:0] ins);
		isBypassIns = !isRingIns(ins) && (ins != INS_IDCODE);
	endfunction

	// path select from the held instruction
	wire selBsr    = isRingIns(irReg_reg);
	wire selId     = (irReg_reg == INS_IDCODE);
	wire selBypass = isBypassIns(irReg_reg);
	wire inIrCol   = (state_reg == ST_CAPIR) || (state_reg == ST_SHIR) ||
	                 (state_reg == ST_EX1IR) || (state_reg == ST_PAUIR) ||
	                 (state_reg == ST_EX2IR) || (state_reg == ST_UPIR);
	wire shiftNow  = (state_reg == ST_SHIR) || (state_reg == ST_SHDR);
	wire capDr     = (state_reg == ST_CAPDR);
	wire shDr      = (state_reg == ST_SHDR);
	wire updBsr    = (irReg_reg == INS_EXTEST) || (irReg_reg == INS_SAMPLE);

	// one serial source at a time
	wire drBit     = selBsr ? bsrShift_reg[0] :
	                 selId  ? idShift_reg[0]  : bypReg_reg;
	wire tdoSel    = inIrCol ? irShift_reg[0] : drBit;

	// output bus float request
	wire floatWant = (irReg_reg == INS_SAMPLEZ) ||
	                 ((irReg_reg == INS_EXTEST) && !bsrUpdate_reg[BSR_FLOAT_BIT]);

	//------------------------------------------------------------
	// controller
	//------------------------------------------------------------
	// next state from sampled mode select
	always_comb begin
		case (state_reg)
			ST_TLR:   state_next = tms ? ST_TLR   : ST_RTI;
			ST_RTI:   state_next = tms ? ST_SELDR : ST_RTI;
			ST_SELDR: state_next = tms ? ST_SELIR : ST_CAPDR;
			ST_CAPDR: state_next = tms ? ST_EX1DR : ST_SHDR;
			ST_SHDR:  state_next = tms ? ST_EX1DR : ST_SHDR;
			ST_EX1DR: state_next = tms ? ST_UPDR  : ST_PAUDR;
			ST_PAUDR: state_next = tms ? ST_EX2DR : ST_PAUDR;
			ST_EX2DR: state_next = tms ? ST_UPDR  : ST_SHDR;
			ST_UPDR:  state_next = tms ? ST_SELDR : ST_RTI;
			ST_SELIR: state_next = tms ? ST_TLR   : ST_CAPIR;
			ST_CAPIR: state_next = tms ? ST_EX1IR : ST_SHIR;
			ST_SHIR:  state_next = tms ? ST_EX1IR : ST_SHIR;
			ST_EX1IR: state_next = tms ? ST_UPIR  : ST_PAUIR;
			ST_PAUIR: state_next = tms ? ST_EX2IR : ST_PAUIR;
			ST_EX2IR: state_next = tms ? ST_UPIR  : ST_SHIR;
			ST_UPIR:  state_next = tms ? ST_SELDR : ST_RTI;
			default:  state_next = ST_TLR;
		endcase
	end

	// state register, rising test clock
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			state_reg <= ST_TLR;
		end else begin
			state_reg <= state_next;
		end
	end

	//------------------------------------------------------------
	// instruction register
	//------------------------------------------------------------
	// capture and shift, rising edge
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			irShift_reg <= IR_CAPTURE;
		end else if (state_reg == ST_CAPIR) begin
			irShift_reg <= IR_CAPTURE;
		end else if (state_reg == ST_SHIR) begin
			irShift_reg <= {tdi, irShift_reg[IR_LEN-1:1]};
		end
	end

	// held instruction, applied on falling edge in update
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			irReg_reg <= INS_IDCODE;
		end else if (state_reg == ST_TLR) begin
			irReg_reg <= INS_IDCODE;
		end else if (state_reg == ST_UPIR) begin
			irReg_reg <= irShift_reg;
		end
	end

	//------------------------------------------------------------
	// data registers
	//------------------------------------------------------------
	// bypass cell
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			bypReg_reg <= BYP_CAPTURE;
		end else if ((state_reg == ST_UPIR) && isBypassIns(irShift_reg)) begin
			bypReg_reg <= BYP_CAPTURE;
		end else if (selBypass && capDr) begin
			bypReg_reg <= BYP_CAPTURE;
		end else if (selBypass && shDr) begin
			bypReg_reg <= tdi;
		end
	end

	// identification shifter
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			idShift_reg <= '0;
		end else if (selId && capDr) begin
			idShift_reg <= ID_CODE;
		end else if (selId && shDr) begin
			idShift_reg <= {tdi, idShift_reg[ID_LEN-1:1]};
		end
	end

	// pin ring into test clock domain
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			ringMeta_reg <= '0;
			ringSync_reg <= '0;
		end else begin
			ringMeta_reg <= pinRing;
			ringSync_reg <= ringMeta_reg;
		end
	end

	// boundary shifter, one cell per bump
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			bsrShift_reg <= '0;
		end else if (selBsr && capDr) begin
			bsrShift_reg <= ringSync_reg;
		end else if (selBsr && shDr) begin
			bsrShift_reg <= {tdi, bsrShift_reg[BSR_LEN-1:1]};
		end
	end

	// preload latch, falling edge in update
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			bsrUpdate_reg <= '0;
		end else if (state_reg == ST_TLR) begin
			bsrUpdate_reg[BSR_FLOAT_BIT] <= FLOAT_RESET;
		end else if ((state_reg == ST_UPDR) && updBsr) begin
			bsrUpdate_reg <= bsrShift_reg;
		end
	end

	//------------------------------------------------------------
	// serial output
	//------------------------------------------------------------
	// driven on falling edge, enabled only while shifting
	always_ff @(negedge tck or posedge rst) begin
		if (rst) begin
			tdoOut_reg <= 1'h0;
			tdoOe_reg  <= 1'h0;
		end else begin
			tdoOut_reg <= tdoSel;
			tdoOe_reg  <= shiftNow;
		end
	end

	//------------------------------------------------------------
	// memory-facing controls
	//------------------------------------------------------------
	// float request and extest flag, test clock side
	always_ff @(posedge tck or posedge rst) begin
		if (rst) begin
			floatReq_reg <= 1'h0;
			extestOn_reg <= 1'h0;
		end else begin
			floatReq_reg <= floatWant;
			extestOn_reg <= (irReg_reg == INS_EXTEST);
		end
	end

	// float level into the core clock domain
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			floatMeta_reg <= 1'h0;
			qBusFloat_reg <= 1'h0;
		end else begin
			floatMeta_reg <= floatReq_reg;
			qBusFloat_reg <= floatMeta_reg;
		end
	end

	assign tdoOut    = tdoOut_reg;
	assign tdoOe     = tdoOe_reg;
	assign bsrDrive  = bsrUpdate_reg;
	assign extestOn  = extestOn_reg;
	assign qBusFloat = qBusFloat_reg;

	//------------------------------------------------------------
	// checks
	//------------------------------------------------------------
	AST_FIVE_HIGH: assert property (@(posedge tck) disable iff (rst)
		tms [*5] |=> (state_reg == ST_TLR))
		else $error("five high mode-select edges did not reach reset");

	AST_IR_IDCODE: assert property (@(posedge tck) disable iff (rst)
		(state_reg == ST_TLR) |=> (irReg_reg == INS_IDCODE))
		else $error("reset state did not load identification instruction");

	AST_IR_CAPTURE: assert property (@(posedge tck) disable iff (rst)
		(state_reg == ST_CAPIR) |=> (irShift_reg[1:0] == IR_CAPTURE[1:0]))
		else $error("instruction capture pattern wrong");

	AST_BYP_ZERO: assert property (@(posedge tck) disable iff (rst)
		(capDr && selBypass) |=> (bypReg_reg == BYP_CAPTURE))
		else $error("bypass did not capture zero");

	AST_ID_LOAD: assert property (@(posedge tck) disable iff (rst)
		(capDr && selId) |=> (idShift_reg == ID_CODE))
		else $error("identification code not captured");

	AST_OE_SHIFT: assert property (@(posedge tck) disable iff (rst)
		tdoOe_reg == shiftNow)
		else $error("serial output enable outside shift states");

	AST_MSB_IN: assert property (@(posedge tck) disable iff (rst)
		(shDr && selBsr) |=> (bsrShift_reg[BSR_LEN-1] == $past(tdi)))
		else $error("serial input not taken into msb");

	AST_IR_PATH: assert property (@(posedge tck) disable iff (rst)
		(state_reg == ST_SHIR) |-> (tdoOut_reg == irShift_reg[0]))
		else $error("instruction path not on serial output");

	AST_FLOAT_XFER: assert property (@(posedge clock) disable iff (rst)
		floatReq_reg [*3] |-> qBusFloat_reg)
		else $error("output bus float not passed to core domain");

	//------------------------------------------------------------
	// checks, serial paths and capture
	//------------------------------------------------------------
	AST_BYP_UPIR: assert property (@(posedge tck) disable iff (rst)
		((state_reg == ST_UPIR) && isBypassIns(irShift_reg)) |=> (bypReg_reg == BYP_CAPTURE))
		else $error("bypass not cleared when bypass applied");

	AST_BYP_SHIFT: assert property (@(posedge tck) disable iff (rst)
		(shDr && selBypass) |=> (bypReg_reg == $past(tdi)))
		else $error("bypass cell did not take serial input");

	AST_BSR_CAPTURE: assert property (@(posedge tck) disable iff (rst)
		(capDr && selBsr) |=> (bsrShift_reg == $past(ringSync_reg)))
		else $error("boundary shifter did not capture pin ring");

	AST_ID_SHIFT: assert property (@(posedge tck) disable iff (rst)
		(shDr && selId) |=> (idShift_reg[ID_LEN-1] == $past(tdi)))
		else $error("identification shifter msb not fed from serial input");

	AST_IR_MSB: assert property (@(posedge tck) disable iff (rst)
		(state_reg == ST_SHIR) |=> (irShift_reg[IR_LEN-1] == $past(tdi)))
		else $error("instruction shifter msb not fed from serial input");

	AST_IR_HOLD: assert property (@(posedge tck) disable iff (rst)
		((state_reg != ST_UPIR) && (state_reg != ST_TLR)) |-> (irReg_reg == $past(irReg_reg)))
		else $error("held instruction changed outside update");

	AST_DR_PATH: assert property (@(posedge tck) disable iff (rst)
		shDr |-> (tdoOut_reg == drBit))
		else $error("selected data path not on serial output");

	AST_SAMPLEZ_FLOAT: assert property (@(posedge tck) disable iff (rst)
		(irReg_reg == INS_SAMPLEZ) |=> floatReq_reg)
		else $error("samplez did not request output bus float");

	AST_NO_FLOAT: assert property (@(posedge clock) disable iff (rst)
		(!floatReq_reg) [*3] |-> !qBusFloat_reg)
		else $error("output bus floated without request");

	AST_EXTEST_FLAG: assert property (@(posedge tck) disable iff (rst)
		(irReg_reg == INS_EXTEST) |=> extestOn_reg)
		else $error("extest flag not raised");

	AST_TLR_CELL: assert property (@(posedge tck) disable iff (rst)
		(state_reg == ST_TLR) |=> (bsrUpdate_reg[BSR_FLOAT_BIT] == FLOAT_RESET))
		else $error("reset state did not clear float control cell");

endmodule

// ### tb/sbst_tester.sv
`timescale 1ns/100ps
// ------------------------------------------------------------
// board tester: makes tck only within frames
// ------------------------------------------------------------
module sbst_tester (
	output logic      tck,     // test clock, low when idle
	output logic      tms,     // mode select
	output logic      tdi,     // serial data to device
	input  wire logic tdoOut,  // serial data from device
	input  wire logic tdoOe    // serial out enable
);
	// idle: clock still, pulled-up lines high
	initial begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b1;
	end

	// one tck period: set lines, sample before the rise
	task automatic cyc(input logic m, input logic d, output logic o, output logic e);
		tms = m;
		tdi = d;
		#80;
		o = tdoOe ? tdoOut : ~tdoOut; // released line reads inverted
		e = tdoOe;
		tck = 1'b1;
		#80;
		tck = 1'b0;
	endtask

	// full scan from idle, back to idle through update
	task automatic scan(input logic ir, input int n, input logic [127:0] din,
			output logic [127:0] dout, output logic oeOk);
		logic o;
		logic e;
		dout = '0;
		oeOk = 1'b1;
		cyc(1'b1, 1'b1, o, e);
		if (ir) begin
			cyc(1'b1, 1'b1, o, e);
		end
		cyc(1'b0, 1'b1, o, e);
		cyc(1'b0, 1'b1, o, e);
		for (int i = 0; i < n; i++) begin
			cyc(i == n - 1, din[i], o, e);
			dout[i] = o;
			oeOk = oeOk & e;
		end
		cyc(1'b1, 1'b1, o, e);
		oeOk = oeOk & !e;
		cyc(1'b0, 1'b1, o, e);
	endtask

	// five high mode-select edges, then to idle
	task automatic reset5;
		logic o;
		logic e;
		repeat (5) cyc(1'b1, 1'b1, o, e);
		cyc(1'b0, 1'b1, o, e);
	endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top
	import sbst_pkg::*;
();
	// ------------------------------------------------------------
	// signals and rows
	// ------------------------------------------------------------
	localparam logic [31:0] ID = 32'h5a5a_0f01; // arbitrary value
	typedef struct packed {
		logic [2:0] code;
		int         n;
		logic       fl;
		logic       ex;
	} sbst_row_s;
	sbst_row_s rows[6] = '{'{INS_IDCODE, 32, 1'b0, 1'b0}, '{INS_BYPASS, 4, 1'b0, 1'b0},
		'{3'h3, 4, 1'b0, 1'b0}, '{INS_SAMPLE, BSR_LEN, 1'b0, 1'b0},
		'{INS_SAMPLEZ, BSR_LEN, 1'b1, 1'b0}, '{INS_EXTEST, BSR_LEN, 1'b0, 1'b1}};
	logic               clock;
	logic               rst;
	wire                tck;
	wire                tms;
	wire                tdi;
	logic               tdoOut;
	logic               tdoOe;
	logic [BSR_LEN-1:0] pins;
	logic [BSR_LEN-1:0] bsrDrive;
	logic               extestOn;
	logic               qBusFloat;
	logic [127:0]       din;
	logic [127:0]       dout;
	logic               oeOk;
	logic               oBit;
	logic               eBit;
	int                 bad_count = 0;
	int                 checked = 0;

	sbst_tap #(.ID_CODE(ID)) i_dut (
		.clock    (clock),
		.rst      (rst),
		.tck      (tck),
		.tms      (tms),
		.tdi      (tdi),
		.tdoOut   (tdoOut),
		.tdoOe    (tdoOe),
		.pinRing  (pins),
		.bsrDrive (bsrDrive),
		.extestOn (extestOn),
		.qBusFloat(qBusFloat)
	);

	sbst_tester i_tester (
		.tck   (tck),
		.tms   (tms),
		.tdi   (tdi),
		.tdoOut(tdoOut),
		.tdoOe (tdoOe)
	);

	// ------------------------------------------------------------
	// compare and closing tasks
	// ------------------------------------------------------------
	task automatic chkBit(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic chkVec(input logic [127:0] got, input logic [127:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t vec got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// expected data-register contents shifted out
	function automatic logic [127:0] expDr(logic [2:0] c);
		if (c == INS_IDCODE) return {96'h0, ID};
		if (c == INS_EXTEST || c == INS_SAMPLE || c == INS_SAMPLEZ) return {20'h0, pins};
		return {124'h0, din[2:0], 1'b0};
	endfunction

	// core clock
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end

	// hang guard
	initial begin
		repeat (90000) @(posedge clock);
		bad_count++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		rst = 1'b1;
		pins = {27{4'ha}};
		din = {20'h0, {27{4'hc}}};
		repeat (12) @(posedge clock);
		@(negedge clock);
		rst = 1'b0;
		chkBit(tdoOe, 1'b0);
		chkBit(qBusFloat, 1'b0);
		chkVec({20'h0, bsrDrive}, 128'h0);
		i_tester.cyc(1'b0, 1'b1, oBit, eBit);
		// instruction table: load, check flags, scan data path
		foreach (rows[r]) begin
			i_tester.scan(1'b1, IR_LEN, {125'h0, rows[r].code}, dout, oeOk);
			chkVec(dout, {125'h0, IR_CAPTURE});
			chkBit(oeOk, 1'b1);
			@(negedge clock);
			chkBit(qBusFloat, rows[r].fl);
			chkBit(extestOn, rows[r].ex);
			i_tester.scan(1'b0, rows[r].n, din, dout, oeOk);
			chkVec(dout, expDr(rows[r].code));
			chkBit(oeOk, 1'b1);
			@(negedge clock);
			if (rows[r].code == INS_SAMPLE) begin
				chkVec({20'h0, bsrDrive}, din);
			end
		end
		// extest with float cell low floats the output bus
		din[BSR_FLOAT_BIT] = 1'b0;
		i_tester.scan(1'b0, BSR_LEN, din, dout, oeOk);
		@(negedge clock);
		chkVec({20'h0, bsrDrive}, din);
		chkBit(qBusFloat, 1'b1);
		// five high edges from the middle of a data shift
		i_tester.cyc(1'b1, 1'b1, oBit, eBit);
		i_tester.cyc(1'b0, 1'b1, oBit, eBit);
		i_tester.cyc(1'b0, 1'b1, oBit, eBit);
		i_tester.reset5();
		@(negedge clock);
		chkBit(extestOn, 1'b0);
		chkBit(qBusFloat, 1'b0);
		chkBit(bsrDrive[BSR_FLOAT_BIT], 1'b0);
		i_tester.scan(1'b0, 32, din, dout, oeOk);
		chkVec(dout, {96'h0, ID});
		report_and_stop();
	end
endmodule
